/* rtl/msc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "msc_params.svh"

module msc_top (
   input  wire logic       CLK,                    // System clock, 125 MHz.
   input  wire logic       RST,                    // Synchronous reset, active high.
   input  wire logic       SER_CLK,                // Serial clock pin from the host.
   input  wire logic       SER_DATA,               // Serial data pin from the host.
   input  wire logic       LATCH_STROBE,           // Latch strobe pin from the host.
   output logic            POWER_DOWN_SELECT,      // One powers the mixer down.
   output logic [2:0]      BALUN_INPUT_CAP_CODE,   // Balun input-side capacitor code.
   output logic [2:0]      BALUN_OUTPUT_CAP_CODE,  // Balun output-side capacitor code.
   output logic [1:0]      IF_FILTER_CODE,         // IF low-pass filter code.
   output logic [2:0]      MIXER_CORE_BIAS_CODE,   // Mixer-core bias code.
   output logic            WORD_ACCEPTED,          // Pulse: a word was latched.
   output logic            WORD_REJECTED           // Pulse: a word was dropped.
);

   msc_pkg::msc_pins_t          pins;      // Synchronised pin events.
   logic [`MSC_WORD_W-1:0]      hold_q;    // Holding shift register.
   logic [`MSC_WORD_W-1:0]      hold_d;    // Holding register after one shift.
   msc_pkg::msc_ctrl_t          ctrl_q;    // Applied control word.
   logic                        acc_q;     // Accept pulse register.
   logic                        rej_q;     // Reject pulse register.

   // True when a word carries the only select value this device answers to.
   function automatic logic sel_ok(input logic [`MSC_WORD_W-1:0] w);
      sel_ok = (w[`MSC_SEL_LSB +: `MSC_SEL_W] == `MSC_SEL_VALUE);
   endfunction : sel_ok

   // Split a raw word into the fields that drive the analog core.
   function automatic msc_pkg::msc_ctrl_t decode(input logic [`MSC_WORD_W-1:0] w);
      decode.bias    = w[`MSC_BIAS_LSB +: 3];
      decode.filt    = w[`MSC_FILT_LSB +: 2];
      decode.out_cap = w[`MSC_OUTCAP_LSB +: 3];
      decode.in_cap  = w[`MSC_INCAP_LSB +: 3];
      decode.pd      = w[`MSC_PD_BIT];
   endfunction : decode

   // All three pins come from the host's domain and pass full synchronisers.
   // Data goes through the same synchroniser, but its level lags the clock's rise pulse by one cycle.
   // Only the edges of the clock and strobe matter, so their levels are left open.
   // three serial lines
   msc_sync u_sync_clk (
      .clk   (CLK),
      .rst   (RST),
      .pin   (SER_CLK),
      .level (),
      .rise  (pins.sclk_rise)
   );

   msc_sync u_sync_data (
      .clk   (CLK),
      .rst   (RST),
      .pin   (SER_DATA),
      .level (pins.data),
      .rise  ()
   );

   msc_sync u_sync_le (
      .clk   (CLK),
      .rst   (RST),
      .pin   (LATCH_STROBE),
      .level (),
      .rise  (pins.latch_rise)
   );

   // Word is shifted MSB first, so the newest bit enters at bit zero.
   assign hold_d = {hold_q[`MSC_WORD_W-2:0], pins.data};

   // Holding register collects serial bits; it never touches the applied word.
   always_ff @(posedge CLK) begin
      if (RST) begin
         hold_q <= '0;
      end else if (pins.sclk_rise) begin
         hold_q <= hold_d;
      end
   end

   // Applied control word; outside reset, only a strobe with a valid select can change it.
   // A strobe in the same cycle as a clock edge latches the word before that bit.
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl_q <= decode(`MSC_RESET_WORD);
      end else if (pins.latch_rise && sel_ok(hold_q)) begin
         ctrl_q <= decode(hold_q);
      end
   end

   // Status pulses tell the system whether the last strobe took effect.
   always_ff @(posedge CLK) begin
      if (RST) begin
         acc_q <= 1'b0;
         rej_q <= 1'b0;
      end else begin
         acc_q <= pins.latch_rise && sel_ok(hold_q);
         rej_q <= pins.latch_rise && !sel_ok(hold_q);
      end
   end

   assign POWER_DOWN_SELECT     = ctrl_q.pd;
   assign BALUN_INPUT_CAP_CODE  = ctrl_q.in_cap;
   assign BALUN_OUTPUT_CAP_CODE = ctrl_q.out_cap;
   assign IF_FILTER_CODE        = ctrl_q.filt;
   assign MIXER_CORE_BIAS_CODE  = ctrl_q.bias;
   assign WORD_ACCEPTED         = acc_q;
   assign WORD_REJECTED         = rej_q;

   // Checks on the register path.
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   logic accept;   // A valid strobe this cycle.
   assign accept = pins.latch_rise && sel_ok(hold_q);

   a_select_accept: assert property (
      accept |=> ctrl_q == decode($past(hold_q)))
      else $error("Valid word was not applied.");

   a_select_reject: assert property (
      pins.latch_rise && !sel_ok(hold_q) |=> $stable(ctrl_q) && WORD_REJECTED)
      else $error("Foreign select word changed the control word.");

   a_power_bit: assert property (
      accept |=> POWER_DOWN_SELECT == $past(hold_q[`MSC_PD_BIT]))
      else $error("Power-down output does not follow bit seven.");

   a_balun_in_code: assert property (
      accept |=> BALUN_INPUT_CAP_CODE == $past(hold_q[11:9]))
      else $error("Balun input code wrong.");

   a_balun_sides_indep: assert property (
      accept |=> BALUN_OUTPUT_CAP_CODE == $past(hold_q[15:13])
                 && BALUN_INPUT_CAP_CODE == $past(hold_q[11:9]))
      else $error("Balun sides not held independently.");

   a_filter_code: assert property (
      accept |=> IF_FILTER_CODE == $past(hold_q[18:17]))
      else $error("IF filter code wrong.");

   a_bias_code: assert property (
      accept |=> MIXER_CORE_BIAS_CODE == $past(hold_q[21:19]))
      else $error("Mixer bias code wrong.");

   a_shift_bit: assert property (
      pins.sclk_rise |=> hold_q[0] == $past(pins.data)
                         && hold_q[`MSC_WORD_W-1:1] == $past(hold_q[`MSC_WORD_W-2:0]))
      else $error("Serial bit not shifted in.");

   a_only_serial: assert property (
      !pins.latch_rise |=> $stable(ctrl_q) && !WORD_ACCEPTED)
      else $error("Control word changed without a strobe.");

   c_word_accepted: cover property (accept ##1 WORD_ACCEPTED);
   c_word_rejected: cover property (pins.latch_rise && !sel_ok(hold_q));
   c_power_down:    cover property (accept && hold_q[`MSC_PD_BIT]);
   c_split_balun:   cover property (accept && hold_q[11:9] != hold_q[15:13]);

endmodule : msc_top

`default_nettype wire

/* rtl/msc_params.svh */
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// Width of one serial word and of the held control word.
`define MSC_WORD_W        22
// Register-select field position, width and the only accepted value.
`define MSC_SEL_LSB       0
`define MSC_SEL_W         3
`define MSC_SEL_VALUE     3'h5
// Field positions inside the control word.
`define MSC_PD_BIT        7
`define MSC_INCAP_LSB     9
`define MSC_OUTCAP_LSB    13
`define MSC_FILT_LSB      17
`define MSC_BIAS_LSB      19
// Reset word: select field set, mixer powered down, all codes zero.
`define MSC_RESET_WORD    22'h000085
// Serial timing minima in ns and the system clock period in ns.
`define MSC_CLK_PERIOD_NS 8
`define MSC_T_CLK_HIGH_NS 25
`define MSC_T_CLK_LOW_NS  25
// Least serial clock phase in system cycles, rounded up.
`define MSC_CLK_PHASE_CYC ((`MSC_T_CLK_HIGH_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)

`endif

/* rtl/msc_pkg.sv */
`default_nettype none

package msc_pkg;

   // Decoded settings that leave the block towards the analog core.
   typedef struct packed {
      logic [2:0] bias;      // Mixer-core bias code.
      logic [1:0] filt;      // IF low-pass filter code.
      logic [2:0] out_cap;   // Balun output-side capacitor code.
      logic [2:0] in_cap;    // Balun input-side capacitor code.
      logic       pd;        // One powers the mixer down.
   } msc_ctrl_t;

   // Synchronised view of the three serial pins.
   typedef struct packed {
      logic data;            // Serial data level.
      logic sclk_rise;       // One-cycle pulse on a serial clock rising edge.
      logic latch_rise;      // One-cycle pulse on a latch strobe rising edge.
   } msc_pins_t;

endpackage : msc_pkg

`default_nettype wire

/* rtl/msc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; a new level counts once stages two and three agree.
module msc_sync (
   input  wire logic clk,      // System clock.
   input  wire logic rst,      // Synchronous reset, active high.
   input  wire logic pin,      // Asynchronous pin level.
   output logic      level,    // Filtered level.
   output logic      rise      // One-cycle pulse on an accepted rising change.
);

   logic s1_q;                 // First stage, read only by the second.
   logic s2_q;                 // Second stage.
   logic s3_q;                 // Third stage.
   logic level_q;              // Accepted level.

   // Shift the pin through the three stages.
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Take a new level only when the last two stages agree, which rejects one-cycle glitches.
   always_ff @(posedge clk) begin
      if (rst) begin
         level_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end

   assign level = level_q;
   assign rise  = (s2_q == s3_q) && s3_q && !level_q;

endmodule : msc_sync

`default_nettype wire

/* verif/msc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host at the far side of the port; it paces the lines from the system clock.
// host drives lines
module msc_host_model (
   input  wire logic clk,          // System clock used for pacing.
   output logic      ser_clk,      // Serial clock, still and low between frames.
   output logic      ser_data,     // Serial data line.
   output logic      latch_strobe  // Latch strobe, idle low.
);
   // All three lines start low so reset sees no edge.
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      latch_strobe = 1'b0;
   end

   // Waits n system edges, then steps just past the last one.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // data before rise
   // Sends 22 bits MSB first, 64 ns per bit, then pulses the strobe.
   task automatic send_word(input logic [21:0] w);
      for (int i = 21; i >= 0; i--) begin
         ser_data = w[i];
         step(4);
         ser_clk = 1'b1;
         step(4);
         ser_clk = 1'b0;
      end
      // Hold has run out, so show the inverse rather than a stale bit.
      ser_data = ~w[0];
      latch_strobe = 1'b1;
      step(4);
      latch_strobe = 1'b0;
   endtask : send_word
endmodule : msc_host_model

`default_nettype wire

/* verif/test_mixer_serial_config_register.sv */
`timescale 1ns/1ps
`default_nettype none

module test_mixer_serial_config_register;
   logic        CLK, RST, SER_CLK, SER_DATA, LATCH_STROBE, PD, ACC, REJ; // Port nets.
   logic [2:0]  IN_CAP, OUT_CAP, BIAS;                                  // Code outputs.
   logic [1:0]  FILT;                                                   // Filter code.
   logic [21:0] exp_word, w;                                            // Model and stimulus.
   int          n_fail, total_checks, n_acc, n_rej, cycles;             // Counters.

   msc_top u_dut (.CLK(CLK), .RST(RST), .SER_CLK(SER_CLK), .SER_DATA(SER_DATA),
      .LATCH_STROBE(LATCH_STROBE), .POWER_DOWN_SELECT(PD), .BALUN_INPUT_CAP_CODE(IN_CAP),
      .BALUN_OUTPUT_CAP_CODE(OUT_CAP), .IF_FILTER_CODE(FILT), .MIXER_CORE_BIAS_CODE(BIAS),
      .WORD_ACCEPTED(ACC), .WORD_REJECTED(REJ));
   msc_host_model u_host (.clk(CLK), .ser_clk(SER_CLK), .ser_data(SER_DATA),
      .latch_strobe(LATCH_STROBE));

   // 125 MHz system clock.
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   // Status pulses are counted at the falling edge, where they stand settled,
   // and a hang is cut short by the cycle ceiling.
   always @(negedge CLK) begin
      cycles++;
      if (ACC === 1'b1) n_acc++;
      if (REJ === 1'b1) n_rej++;
      if (cycles == 6000) begin
         n_fail++;
         test_done();
      end
   end

   // Compares two values with case equality and reports a difference.
   task automatic check(input logic [21:0] seen, input logic [21:0] expv);
      total_checks++;
      if (seen !== expv) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expv);
      end
   endtask : check

   // Rebuilds the word from the outputs; unused bits read as zero, select as five.
   task automatic check_outputs();
      logic [21:0] seen;   // Word rebuilt from the outputs.
      seen = {BIAS, FILT, 1'b0, OUT_CAP, 1'b0, IN_CAP, 1'b0, PD, 7'h05};
      check(seen, exp_word);
   endtask : check_outputs

   // Sends a word, lets the four-edge answer land, and tracks the expected word.
   task automatic send(input logic [21:0] wd);
      u_host.send_word(wd);
      repeat (6) @(posedge CLK);
      if (wd[2:0] === 3'h5) exp_word = (wd & 22'h3eee80) | 22'h000005;
   endtask : send

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   // Main sequence: reset word, every select value, back-to-back words.
   initial begin
      RST = 1'b1;
      n_fail = 0;
      total_checks = 0;
      n_acc = 0;
      n_rej = 0;
      cycles = 0;
      repeat (4) @(posedge CLK);
      #1 RST = 1'b0;
      exp_word = 22'h000085;
      check_outputs();
      for (int i = 0; i < 8; i++) begin
         w = {3'(i), 2'(i + 1), 1'b1, 3'(7 - i), 1'b1, 3'(i + 2), 1'b1, i[0], 4'hf, 3'(i)};
         send(w);
         check_outputs();
         check(22'(n_acc), 22'(i >= 5));
         check(22'(n_rej), 22'(i < 5 ? i + 1 : i));
      end
      // Two words with no idle between; only the second must remain.
      // select field five
      u_host.send_word(22'h3eee05);
      send(22'h2a4a05);
      check_outputs();
      check(22'(n_acc), 22'h3);
      // Power up with every code at its top value.
      // same code both sides
      send(22'h3eee05);
      check_outputs();
      // A mid-run reset must bring back the reset word and leave the port usable.
      #1 RST = 1'b1;
      repeat (4) @(posedge CLK);
      #1 RST = 1'b0;
      exp_word = 22'h000085;
      check_outputs();
      send(22'h2a4a05);
      check_outputs();
      check(22'(n_acc), 22'h5);
      test_done();
   end
endmodule : test_mixer_serial_config_register

`default_nettype wire
